// [include/ebm_consts.vh]
// Constants for the embedded block memory: register map, fields, codes
`ifndef EBM_CONSTS_VH
`define EBM_CONSTS_VH
// Register byte offsets
`define EBM_REG_CTRL 8'h00
`define EBM_REG_CFG_A 8'h04
`define EBM_REG_CFG_B 8'h08
`define EBM_REG_INIT_ADDR 8'h0C
`define EBM_REG_INIT_DATA 8'h10
`define EBM_REG_INIT_HI 8'h14
`define EBM_REG_STATUS 8'h18
// Control fields
`define EBM_CTRL_RUN 0
`define EBM_CTRL_MODE_HI 2
`define EBM_CTRL_MODE_LO 1
// Port config fields
`define EBM_CFG_WID_HI 2
`define EBM_CFG_WID_LO 0
`define EBM_CFG_WM_HI 4
`define EBM_CFG_WM_LO 3
`define EBM_CFG_OREG 5
`define EBM_CFG_SYNC 6
`define EBM_CFG_PAR 7
// Status fields
`define EBM_ST_RUN 0
`define EBM_ST_BAD 1
`define EBM_ST_PERR_A 2
`define EBM_ST_PERR_B 3
// Memory modes
`define EBM_MODE_SINGLE 2'h0
`define EBM_MODE_TDP 2'h1
`define EBM_MODE_PDP 2'h2
// Width codes
`define EBM_W_X1 3'h0
`define EBM_W_X2 3'h1
`define EBM_W_X4 3'h2
`define EBM_W_X9 3'h3
`define EBM_W_X18 3'h4
`define EBM_W_X36 3'h5
// Write modes
`define EBM_WM_NORMAL 2'h0
`define EBM_WM_THRU 2'h1
`define EBM_WM_RBW 2'h2
// Array geometry
`define EBM_ARRAY_BITS 18432
`define EBM_ROW_BITS 36
`define EBM_LANE_BITS 9
`define EBM_LANES 4
`endif

// [design/ebm_parity.v]
// Per-byte parity generation on write data and checking on read data
`timescale 1ns/1ns
`include "ebm_consts.vh"
module ebm_parity (
  input wire enable,
  input wire [2:0] lanes,
  input wire [35:0] wdata,
  input wire [35:0] rdata,
  output reg [35:0] wdata_par,
  output reg rdata_err
);
  integer i;
  // Ninth bit of each active lane carries even parity of its byte
  always @* begin
    wdata_par = wdata;
    rdata_err = 1'b0;
    for (i = 0; i < `EBM_LANES; i = i + 1) begin
      if (enable && i < lanes) begin
        wdata_par[i*`EBM_LANE_BITS+8] = ^wdata[i*`EBM_LANE_BITS +: 8]; // [RULE3]
        if (rdata[i*`EBM_LANE_BITS+8] != ^rdata[i*`EBM_LANE_BITS +: 8]) begin
          rdata_err = 1'b1; // [RULE3]
        end
      end
    end
  end
endmodule // ebm_parity

// [design/ebm_port.v]
// One memory port: input registers, output latch, optional output register
`timescale 1ns/1ns
`include "ebm_consts.vh"
module ebm_port #(
  parameter AW = 14,
  parameter DW = 36
) (
  input wire hclk,
  input wire hresetn,
  input wire latch_rst_n,
  input wire clr_sync,
  input wire ce,
  input wire en,
  input wire rd_en,
  input wire we,
  input wire [3:0] be,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  input wire [1:0] wmode,
  input wire outreg,
  input wire [DW-1:0] arr_rdata,
  input wire arr_err,
  output reg [AW-1:0] addr_reg,
  output reg [DW-1:0] wdata_reg,
  output reg we_reg,
  output reg [3:0] be_reg,
  output wire acc,
  output wire [DW-1:0] dout,
  output wire err
);
  reg [DW-1:0] latch_reg;
  reg [DW-1:0] oreg_reg;
  reg err_latch_reg;
  reg err_oreg_reg;

  // Access happens only on enabled edges
  assign acc = ce & en; // [RULE18]

  // Address and data are captured before the array sees them
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= {AW{1'b0}};
      wdata_reg <= {DW{1'b0}};
      we_reg <= 1'b0;
      be_reg <= 4'h0;
    end else if (ce) begin // [RULE9] [RULE18]
      addr_reg <= addr;
      wdata_reg <= wdata;
      we_reg <= we;
      be_reg <= be;
    end
  end

  // Output latch; its reset may be async (latch_rst_n) or sync (clr_sync)
  always @(posedge hclk or negedge latch_rst_n) begin
    if (!latch_rst_n) begin
      latch_reg <= {DW{1'b0}}; // [RULE14]
      err_latch_reg <= 1'b0;
    end else if (clr_sync) begin
      latch_reg <= {DW{1'b0}}; // [RULE14]
      err_latch_reg <= 1'b0;
    end else if (acc) begin
      if (!we_reg) begin
        if (rd_en) begin
          latch_reg <= arr_rdata;
          err_latch_reg <= arr_err;
        end
      end else begin
        case (wmode)
          `EBM_WM_THRU: latch_reg <= wdata_reg; // [RULE12]
          `EBM_WM_RBW: latch_reg <= arr_rdata; // [RULE13]
          default: latch_reg <= latch_reg; // [RULE11]
        endcase
      end
    end
  end

  // Optional pipeline stage after the latch
  always @(posedge hclk or negedge latch_rst_n) begin
    if (!latch_rst_n) begin
      oreg_reg <= {DW{1'b0}};
      err_oreg_reg <= 1'b0;
    end else if (clr_sync) begin
      oreg_reg <= {DW{1'b0}};
      err_oreg_reg <= 1'b0;
    end else if (ce) begin
      oreg_reg <= latch_reg;
      err_oreg_reg <= err_latch_reg;
    end
  end

  // Bypass skips one register stage
  assign dout = outreg ? oreg_reg : latch_reg; // [RULE10]
  assign err = outreg ? err_oreg_reg : err_latch_reg;
endmodule // ebm_port

// [design/ebm_top.v]
// Dual-port embedded block memory with AHB-Lite configuration and preload
// Overview of operation
// (RULE1) 18 Kb array with input/output registers and a clock enable per port.
// (RULE2) Shapes 16384x1 to 512x36; true dual-port stops at 1024x18.
// (RULE3) Optional parity bit stored with each data byte, checked on read.
// (RULE4) Byte write enables apply at 18-bit and 36-bit widths.
// (RULE5) The two ports may use different widths on the same array.
// (RULE6) Word n occupies bits n*width upward, lsb first, per port.
// (RULE7) Array may be preloaded before user operation starts.
// (RULE8) For read-only use, fabric preloads and keeps write enables low.
// (RULE9) Port address and data are registered before the array access.
// (RULE10) Output register is optional; bypass gives data one stage earlier.
// (RULE11) Normal mode: output changes only on reads, never on writes.
// (RULE12) Write-through: written data appears on the same port output.
// (RULE13) Read-before-write shows old contents; only for 9, 18, 36 widths.
// (RULE14) Output latches clear by reset, async or sync per port.
// (RULE15) Each port has a local clear acting only on its own outputs.
// (RULE16) Active-low device-wide clear resets both ports' outputs.
// (RULE17) FIFO control lives in fabric logic, not in this block.
// (RULE18) With clock enable low a port holds registers and does no access.
`timescale 1ns/1ns
`include "ebm_consts.vh"
module ebm_top #(
  parameter AW = 14,
  parameter DW = 36
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire device_wide_clear_n,
  input wire port_a_ce,
  input wire port_a_we,
  input wire [3:0] port_a_be,
  input wire [AW-1:0] port_a_addr,
  input wire [DW-1:0] port_a_wdata,
  input wire port_a_output_clear,
  output wire [DW-1:0] port_a_rdata,
  output wire port_a_parity_err,
  input wire port_b_ce,
  input wire port_b_we,
  input wire [3:0] port_b_be,
  input wire [AW-1:0] port_b_addr,
  input wire [DW-1:0] port_b_wdata,
  input wire port_b_output_clear,
  output wire [DW-1:0] port_b_rdata,
  output wire port_b_parity_err
);
  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  // Width in bits for a width code
  function [5:0] ebm_width;
    input [2:0] code;
    begin
      case (code)
        `EBM_W_X1: ebm_width = 6'h01;
        `EBM_W_X2: ebm_width = 6'h02;
        `EBM_W_X4: ebm_width = 6'h04;
        `EBM_W_X9: ebm_width = 6'h09;
        `EBM_W_X18: ebm_width = 6'h12;
        default: ebm_width = 6'h24;
      endcase
    end
  endfunction

  // First array bit of a word; address bits above the depth are ignored
  function [14:0] ebm_base;
    input [13:0] addr;
    input [2:0] code;
    begin
      case (code)
        `EBM_W_X1: ebm_base = {1'b0, addr}; // [RULE6]
        `EBM_W_X2: ebm_base = {1'b0, addr[12:0], 1'b0};
        `EBM_W_X4: ebm_base = {1'b0, addr[11:0], 2'h0};
        `EBM_W_X9: ebm_base = {4'h0, addr[10:0]} * 15'h0009;
        `EBM_W_X18: ebm_base = {5'h00, addr[9:0]} * 15'h0012;
        default: ebm_base = {6'h00, addr[8:0]} * 15'h0024;
      endcase
    end
  endfunction

  // Mask of the valid data bits of a word
  function [35:0] ebm_mask;
    input [2:0] code;
    integer k;
    begin
      ebm_mask = 36'h000000000;
      for (k = 0; k < `EBM_ROW_BITS; k = k + 1) begin
        if (k < ebm_width(code)) begin
          ebm_mask[k] = 1'b1;
        end
      end
    end
  endfunction

  // Number of 9-bit lanes carrying parity
  function [2:0] ebm_lanes;
    input [2:0] code;
    begin
      case (code)
        `EBM_W_X9: ebm_lanes = 3'h1;
        `EBM_W_X18: ebm_lanes = 3'h2;
        `EBM_W_X36: ebm_lanes = 3'h4;
        default: ebm_lanes = 3'h0;
      endcase
    end
  endfunction

  // Read-before-write only exists for byte-lane widths
  function [1:0] ebm_wmode;
    input [1:0] wm;
    input [2:0] code;
    begin
      if (wm == `EBM_WM_RBW && code < `EBM_W_X9) begin
        ebm_wmode = `EBM_WM_NORMAL; // [RULE13]
      end else if (wm > `EBM_WM_RBW) begin
        ebm_wmode = `EBM_WM_NORMAL;
      end else begin
        ebm_wmode = wm;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration state
  reg [2:0] ctrl_reg;
  reg [7:0] cfg_a_reg;
  reg [7:0] cfg_b_reg;
  reg [8:0] init_addr_reg;
  reg [3:0] init_hi_reg;
  reg perr_a_reg;
  reg perr_b_reg;
  reg wr_ph_reg;
  reg [7:0] ad_ph_reg;
  reg [31:0] hrdata_reg;
  reg [1:0] gclr_sync_reg;
  reg [`EBM_ARRAY_BITS+`EBM_ROW_BITS-1:0] mem;

  wire run = ctrl_reg[`EBM_CTRL_RUN];
  wire [1:0] mode = ctrl_reg[`EBM_CTRL_MODE_HI:`EBM_CTRL_MODE_LO];
  wire [2:0] wid_a_raw = cfg_a_reg[`EBM_CFG_WID_HI:`EBM_CFG_WID_LO];
  wire [2:0] wid_b_raw = cfg_b_reg[`EBM_CFG_WID_HI:`EBM_CFG_WID_LO];
  wire tdp = (mode == `EBM_MODE_TDP);
  // True dual-port has no 36-bit shape; out-of-range codes fall back too
  wire bad_a = (wid_a_raw > `EBM_W_X36) | (tdp & (wid_a_raw == `EBM_W_X36));
  wire bad_b = (wid_b_raw > `EBM_W_X36) | (tdp & (wid_b_raw == `EBM_W_X36));
  wire [2:0] wid_a = bad_a ? `EBM_W_X18 : wid_a_raw; // [RULE2] [RULE5]
  wire [2:0] wid_b = bad_b ? `EBM_W_X18 : wid_b_raw; // [RULE2] [RULE5]
  wire [5:0] w_a = ebm_width(wid_a);
  wire [5:0] w_b = ebm_width(wid_b);
  wire [35:0] mask_a = ebm_mask(wid_a);
  wire [35:0] mask_b = ebm_mask(wid_b);

  ////////////////////////////////////////////////////////////////////////////
  // Device-wide clear: async assert, release after two flops
  always @(posedge hclk or negedge device_wide_clear_n) begin
    if (!device_wide_clear_n) begin
      gclr_sync_reg <= 2'h0;
    end else begin
      gclr_sync_reg <= {gclr_sync_reg[0], 1'b1};
    end
  end
  wire gclr_n = gclr_sync_reg[1];

  // Latch reset: async path only when the port is set for async clearing
  wire a_sync = cfg_a_reg[`EBM_CFG_SYNC];
  wire b_sync = cfg_b_reg[`EBM_CFG_SYNC];
  wire lrst_a_n = hresetn & gclr_n & ~(~a_sync & port_a_output_clear); // [RULE14] [RULE16]
  wire lrst_b_n = hresetn & gclr_n & ~(~b_sync & port_b_output_clear); // [RULE14] [RULE16]
  wire clr_a = a_sync & port_a_output_clear; // [RULE15]
  wire clr_b = b_sync & port_b_output_clear; // [RULE15]

  ////////////////////////////////////////////////////////////////////////////
  // Ports: single mode uses A only; pseudo dual writes on A, reads on B
  wire a_en = run;
  wire b_en = run & (mode != `EBM_MODE_SINGLE);
  wire a_rd_en = (mode != `EBM_MODE_PDP);
  wire b_we_ok = (mode != `EBM_MODE_PDP);

  wire [35:0] a_wd_par;
  wire [35:0] b_wd_par;
  wire [35:0] a_rd;
  wire [35:0] b_rd;
  wire a_rd_err;
  wire b_rd_err;
  wire [AW-1:0] a_addr_q;
  wire [AW-1:0] b_addr_q;
  wire [DW-1:0] a_wd_q;
  wire [DW-1:0] b_wd_q;
  wire a_we_q;
  wire b_we_q;
  wire [3:0] a_be_q;
  wire [3:0] b_be_q;
  wire a_acc;
  wire b_acc;

  ebm_parity u_par_a (
    .enable(cfg_a_reg[`EBM_CFG_PAR]),
    .lanes(ebm_lanes(wid_a)),
    .wdata(port_a_wdata),
    .rdata(a_rd),
    .wdata_par(a_wd_par),
    .rdata_err(a_rd_err)
  );

  ebm_parity u_par_b (
    .enable(cfg_b_reg[`EBM_CFG_PAR]),
    .lanes(ebm_lanes(wid_b)),
    .wdata(port_b_wdata),
    .rdata(b_rd),
    .wdata_par(b_wd_par),
    .rdata_err(b_rd_err)
  );

  ebm_port #(.AW(AW), .DW(DW)) u_port_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .latch_rst_n(lrst_a_n),
    .clr_sync(clr_a),
    .ce(port_a_ce),
    .en(a_en),
    .rd_en(a_rd_en),
    .we(port_a_we),
    .be(port_a_be),
    .addr(port_a_addr),
    .wdata(a_wd_par & mask_a),
    .wmode(ebm_wmode(cfg_a_reg[`EBM_CFG_WM_HI:`EBM_CFG_WM_LO], wid_a)),
    .outreg(cfg_a_reg[`EBM_CFG_OREG]),
    .arr_rdata(a_rd),
    .arr_err(a_rd_err),
    .addr_reg(a_addr_q),
    .wdata_reg(a_wd_q),
    .we_reg(a_we_q),
    .be_reg(a_be_q),
    .acc(a_acc),
    .dout(port_a_rdata),
    .err(port_a_parity_err)
  );

  ebm_port #(.AW(AW), .DW(DW)) u_port_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .latch_rst_n(lrst_b_n),
    .clr_sync(clr_b),
    .ce(port_b_ce),
    .en(b_en),
    .rd_en(1'b1),
    .we(port_b_we & b_we_ok),
    .be(port_b_be),
    .addr(port_b_addr),
    .wdata(b_wd_par & mask_b),
    .wmode(ebm_wmode(cfg_b_reg[`EBM_CFG_WM_HI:`EBM_CFG_WM_LO], wid_b)),
    .outreg(cfg_b_reg[`EBM_CFG_OREG]),
    .arr_rdata(b_rd),
    .arr_err(b_rd_err),
    .addr_reg(b_addr_q),
    .wdata_reg(b_wd_q),
    .we_reg(b_we_q),
    .be_reg(b_be_q),
    .acc(b_acc),
    .dout(port_b_rdata),
    .err(port_b_parity_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Array: flat bit vector so each port maps words at its own width
  wire [14:0] a_base = ebm_base(a_addr_q, wid_a);
  wire [14:0] b_base = ebm_base(b_addr_q, wid_b);
  wire [14:0] init_base = {6'h00, init_addr_reg} * 15'h0024;
  wire [35:0] init_rd = mem[init_base +: `EBM_ROW_BITS];
  assign a_rd = mem[a_base +: `EBM_ROW_BITS] & mask_a; // [RULE6]
  assign b_rd = mem[b_base +: `EBM_ROW_BITS] & mask_b; // [RULE6]

  wire init_wr = wr_ph_reg & (ad_ph_reg == `EBM_REG_INIT_DATA) & ~run;
  wire a_wr = a_acc & a_we_q;
  wire b_wr = b_acc & b_we_q;
  integer i;

  // Port B wins a same-bit collision at equal word offsets, else the lower word offset wins; byte enables only at wide shapes
  always @(posedge hclk) begin
    if (init_wr) begin
      mem[init_base +: `EBM_ROW_BITS] <= {init_hi_reg, hwdata}; // [RULE7]
    end
    for (i = 0; i < `EBM_ROW_BITS; i = i + 1) begin
      if (a_wr && i < w_a && (wid_a < `EBM_W_X18 || a_be_q[i/`EBM_LANE_BITS])) begin
        mem[a_base + i] <= a_wd_q[i]; // [RULE1] [RULE4]
      end
      if (b_wr && i < w_b && (wid_b < `EBM_W_X18 || b_be_q[i/`EBM_LANE_BITS])) begin
        mem[b_base + i] <= b_wd_q[i]; // [RULE1] [RULE4]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  wire ahb_go = hsel & htrans[1] & hready;
  wire [3:0] st_word = {perr_b_reg, perr_a_reg, bad_a | bad_b, run};
  reg [31:0] rd_mux;

  // Read data is chosen from the address phase
  always @* begin
    case (haddr[7:0])
      `EBM_REG_CTRL: rd_mux = {29'h00000000, ctrl_reg};
      `EBM_REG_CFG_A: rd_mux = {24'h000000, cfg_a_reg};
      `EBM_REG_CFG_B: rd_mux = {24'h000000, cfg_b_reg};
      `EBM_REG_INIT_ADDR: rd_mux = {23'h000000, init_addr_reg};
      `EBM_REG_INIT_DATA: rd_mux = init_rd[31:0];
      `EBM_REG_INIT_HI: rd_mux = {28'h0000000, init_rd[35:32]};
      `EBM_REG_STATUS: rd_mux = {28'h0000000, st_word};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Parity events from reads feed sticky status bits
  wire perr_a_ev = a_acc & ~a_we_q & a_rd_en & a_rd_err;
  wire perr_b_ev = b_acc & ~b_we_q & b_rd_err;
  wire st_wr = wr_ph_reg & (ad_ph_reg == `EBM_REG_STATUS);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_reg <= 1'b0;
      ad_ph_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      ctrl_reg <= 3'h0;
      cfg_a_reg <= 8'h00;
      cfg_b_reg <= 8'h00;
      init_addr_reg <= 9'h000;
      init_hi_reg <= 4'h0;
      perr_a_reg <= 1'b0;
      perr_b_reg <= 1'b0;
    end else begin
      wr_ph_reg <= ahb_go & hwrite;
      ad_ph_reg <= haddr[7:0];
      if (ahb_go && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
      // Set beats a write-one clear in the same cycle
      perr_a_reg <= (perr_a_reg & ~(st_wr & hwdata[`EBM_ST_PERR_A])) | perr_a_ev;
      perr_b_reg <= (perr_b_reg & ~(st_wr & hwdata[`EBM_ST_PERR_B])) | perr_b_ev;
      if (wr_ph_reg) begin
        case (ad_ph_reg)
          `EBM_REG_CTRL: ctrl_reg <= hwdata[2:0];
          `EBM_REG_CFG_A: cfg_a_reg <= hwdata[7:0];
          `EBM_REG_CFG_B: cfg_b_reg <= hwdata[7:0];
          `EBM_REG_INIT_ADDR: init_addr_reg <= hwdata[8:0];
          `EBM_REG_INIT_HI: init_hi_reg <= hwdata[3:0];
          `EBM_REG_INIT_DATA: begin
            if (!run) begin
              init_addr_reg <= init_addr_reg + 9'h001; // [RULE7]
            end
          end
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule // ebm_top

// [bench/ebm_top_monitor.sv]
// Port-level assertions for the embedded block memory top
`timescale 1ns/1ns
module ebm_top_monitor #(
  parameter AW = 14,
  parameter DW = 36
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire device_wide_clear_n,
  input wire port_a_ce,
  input wire port_a_output_clear,
  input wire [DW-1:0] port_a_rdata,
  input wire port_a_parity_err,
  input wire port_b_ce,
  input wire port_b_output_clear,
  input wire [DW-1:0] port_b_rdata
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////
  // Bus side: zero wait, OKAY, read data held between reads
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus wait or error seen");
  chk_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("hrdata moved without a read");
  ////////////////////////////////////////
  // Clears: device-wide clears both, local clears only its own
  chk_global_clear: assert property (!device_wide_clear_n |->
    port_a_rdata == 0 && port_b_rdata == 0)
    else $error("device clear left data");
  chk_a_clear: assert property (port_a_output_clear |=>
    port_a_rdata == 0 && !port_a_parity_err)
    else $error("port a clear left data");
  chk_b_clear: assert property (port_b_output_clear |=> port_b_rdata == 0)
    else $error("port b clear left data");
  chk_b_isolated: assert property ($rose(port_a_output_clear) &&
    device_wide_clear_n && !port_b_output_clear && !port_b_ce |=> $stable(port_b_rdata))
    else $error("port a clear hit port b");
  ////////////////////////////////////////
  // Clock enable low freezes the outputs unless a clear acts
  chk_a_ce_hold: assert property (!port_a_ce && !port_a_output_clear &&
    device_wide_clear_n |=> $stable(port_a_rdata) || port_a_output_clear ||
    !device_wide_clear_n)
    else $error("port a moved with ce low");
  chk_b_ce_hold: assert property (!port_b_ce && !port_b_output_clear &&
    device_wide_clear_n |=> $stable(port_b_rdata) || port_b_output_clear ||
    !device_wide_clear_n)
    else $error("port b moved with ce low");
endmodule // ebm_top_monitor

bind ebm_top ebm_top_monitor #(.AW(AW), .DW(DW)) ebm_top_monitor_inst (.hclk, .hresetn, .hsel,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .device_wide_clear_n, .port_a_ce,
  .port_a_output_clear, .port_a_rdata, .port_a_parity_err, .port_b_ce, .port_b_output_clear,
  .port_b_rdata);

// [bench/ebm_fabric.sv]
// Fabric-side driver model for one memory port
`timescale 1ns/1ns
module ebm_fabric (
  input wire hclk,
  output logic ce,
  output logic we,
  output logic [3:0] be,
  output logic [13:0] addr,
  output logic [35:0] wdata
);
  // Idle port; any FIFO pointers or flags belong out here, not in the block
  initial begin
    ce = 1'b0;
    we = 1'b0;
    be = 4'h0;
    addr = 14'h0000;
    wdata = 36'h000000000;
  end
  // One access: capture edge, access edge, then ext edges for the output register
  task automatic acc(input logic w, input logic [3:0] b, input logic [13:0] a,
                     input logic [35:0] d, input int ext);
    @(posedge hclk);
    ce <= 1'b1;
    we <= w;
    be <= b;
    addr <= a;
    wdata <= d;
    repeat (2 + ext) @(posedge hclk);
    // Strobes drop and the other lines flip so a stale value never looks live
    ce <= 1'b0;
    we <= 1'b0; // Writes stay off outside accesses, as ROM use needs
    be <= ~b;
    addr <= ~a;
    wdata <= ~d;
  endtask
endmodule // ebm_fabric

// [bench/ebm_top_tb.sv]
// Self-checking bench for the embedded block memory top
`timescale 1ns/1ns
`include "ebm_consts.vh"
module ebm_top_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic dclr_n = 1'b1;
  logic a_clr = 1'b0;
  logic b_clr = 1'b0;
  wire hready, hresp, a_ce, a_we, b_ce, b_we, a_perr, b_perr;
  wire [31:0] hrdata;
  wire [3:0] a_be, b_be;
  wire [13:0] a_addr, b_addr;
  wire [35:0] a_wd, b_wd, a_rd, b_rd;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rv;
  logic [35:0] hold;
  // Preload image, row 0 lowest
  logic [143:0] img = 144'h3C3C3C3C3_A5A5A5A5A_123456789_987654321;
  // Rows: port (0 a, 1 b), width code, word address
  int rows [8][3] = '{'{0, 4, 0}, '{1, 4, 3}, '{0, 3, 5}, '{1, 3, 15}, '{0, 2, 17},
                      '{1, 2, 35}, '{0, 1, 30}, '{1, 0, 97}};
  ////////////////////////////////////////
  ebm_top ebm_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .device_wide_clear_n(dclr_n),
    .port_a_ce(a_ce), .port_a_we(a_we), .port_a_be(a_be), .port_a_addr(a_addr),
    .port_a_wdata(a_wd), .port_a_output_clear(a_clr), .port_a_rdata(a_rd),
    .port_a_parity_err(a_perr), .port_b_ce(b_ce), .port_b_we(b_we), .port_b_be(b_be),
    .port_b_addr(b_addr), .port_b_wdata(b_wd), .port_b_output_clear(b_clr),
    .port_b_rdata(b_rd), .port_b_parity_err(b_perr));
  ebm_fabric ebm_fabric_a_inst (.hclk(hclk), .ce(a_ce), .we(a_we), .be(a_be), .addr(a_addr),
    .wdata(a_wd));
  ebm_fabric ebm_fabric_b_inst (.hclk(hclk), .ce(b_ce), .we(b_we), .be(b_be), .addr(b_addr),
    .wdata(b_wd));
  ////////////////////////////////////////
  // Clock and hang guard
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      $display("mismatch at %0t: run timed out", $time);
      final_report();
    end
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Single-word AHB-Lite transfer; read data lands in rv
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask
  // Word a at width code wc, lsb-first packing over the image
  function automatic logic [35:0] word(input int wc, input int a);
    int w;
    w = wc < 3 ? (1 << wc) : (9 << (wc - 3));
    return 36'((img >> (a * w)) & ((144'h1 << w) - 1));
  endfunction
  function automatic void put(input int a, input logic [35:0] d);
    img = (img & ~(144'h1FF << (a * 9))) | (144'(d & 36'h1FF) << (a * 9));
  endfunction
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk(a_rd, 36'h0, "reset output");
    ahb(1'b1, `EBM_REG_CFG_A, 32'h00000025);
    ahb(1'b0, `EBM_REG_CFG_A, 32'h0);
    chk(36'(rv), 36'h25, "config readback");
    ahb(1'b0, 8'h1C, 32'h0);
    chk(36'(rv), 36'h0, "unmapped read");
    // Preload while stopped, then run as true dual port
    ahb(1'b1, `EBM_REG_INIT_ADDR, 32'h0);
    for (int r = 0; r < 4; r++) begin
      ahb(1'b1, `EBM_REG_INIT_HI, {28'h0, img[r*36+32 +: 4]});
      ahb(1'b1, `EBM_REG_INIT_DATA, img[r*36 +: 32]);
    end
    ahb(1'b1, `EBM_REG_CTRL, 32'h00000003);
    foreach (rows[i]) begin
      ahb(1'b1, rows[i][0] ? `EBM_REG_CFG_B : `EBM_REG_CFG_A, 32'(rows[i][1]));
      if (rows[i][0] == 1) ebm_fabric_b_inst.acc(1'b0, 4'h0, 14'(rows[i][2]), 36'h0, 0);
      else ebm_fabric_a_inst.acc(1'b0, 4'h0, 14'(rows[i][2]), 36'h0, 0);
      #1;
      hold = word(rows[i][1], rows[i][2]);
      chk(rows[i][0] ? b_rd : a_rd, hold, "width read");
      repeat (3) @(posedge hclk);
      #1;
      chk(rows[i][0] ? b_rd : a_rd, hold, "ce low hold");
      $display("row %0d done", i);
    end
    // Write modes at x9: read word 9, then write word m
    for (int m = 0; m < 3; m++) begin
      ahb(1'b1, `EBM_REG_CFG_A, {27'h0, 2'(m), 3'h3});
      ebm_fabric_a_inst.acc(1'b0, 4'h0, 14'h9, 36'h0, 0);
      hold = (m == 2) ? word(3, m) : word(3, 9);
      if (m == 1) hold = 36'h1C3 + 36'(m);
      ebm_fabric_a_inst.acc(1'b1, 4'hF, 14'(m), 36'h1C3 + 36'(m), 0);
      #1;
      chk(a_rd, hold, "write mode output");
      put(m, 36'h1C3 + 36'(m));
      $display("write mode %0d done", m);
    end
    ebm_fabric_a_inst.acc(1'b0, 4'h0, 14'h1, 36'h0, 0);
    #1;
    chk(a_rd, word(3, 1), "written word");
    // Parity at x9: word 0 holds a bad ninth bit, a fresh write gets a good one
    ahb(1'b1, `EBM_REG_CFG_A, 32'h00000083);
    ebm_fabric_a_inst.acc(1'b0, 4'h0, 14'h0, 36'h0, 0);
    #1;
    hold = word(3, 0);
    chk(36'(a_perr), 36'(hold[8] ^ (^hold[7:0])), "parity flag");
    ebm_fabric_a_inst.acc(1'b1, 4'h0, 14'h4, 36'h001, 0);
    ebm_fabric_a_inst.acc(1'b0, 4'h0, 14'h4, 36'h0, 0);
    #1;
    chk(a_rd, 36'h101, "parity bit made");
    chk(36'(a_perr), 36'h0, "parity clean");
    put(4, 36'h101);
    ahb(1'b0, `EBM_REG_STATUS, 32'h0);
    chk(36'(rv[`EBM_ST_PERR_A]), 36'h1, "sticky parity");
    $display("parity done");
    // Byte enables at x18, then the output register stage
    ahb(1'b1, `EBM_REG_CFG_A, 32'h00000004);
    ebm_fabric_a_inst.acc(1'b1, 4'h2, 14'h3, 36'hFFFFFFFFF, 0);
    ebm_fabric_a_inst.acc(1'b0, 4'h0, 14'h3, 36'h0, 1);
    #1;
    chk(a_rd, word(4, 3) | 36'h3FE00, "byte enable");
    ahb(1'b1, `EBM_REG_CFG_A, 32'h00000024);
    ebm_fabric_a_inst.acc(1'b0, 4'h0, 14'h1, 36'h0, 1);
    #1;
    chk(a_rd, word(4, 1), "output register");
    ebm_fabric_a_inst.acc(1'b0, 4'h0, 14'h2, 36'h0, 0);
    #1;
    chk(a_rd, word(4, 1), "one stage later");
    // Let the output stage catch up so dropping it moves nothing
    ebm_fabric_a_inst.acc(1'b0, 4'h0, 14'h2, 36'h0, 1);
    #1;
    chk(a_rd, word(4, 2), "stage caught up");
    ahb(1'b1, `EBM_REG_CFG_A, 32'h00000005);
    ahb(1'b0, `EBM_REG_STATUS, 32'h0);
    chk(36'(rv[`EBM_ST_BAD]), 36'h1, "x36 in dual");
    $display("widths done");
    // Clears: local async on a, local sync on b, then device-wide
    ahb(1'b1, `EBM_REG_CFG_A, 32'h00000004);
    ahb(1'b1, `EBM_REG_CFG_B, 32'h00000044);
    ebm_fabric_a_inst.acc(1'b0, 4'h0, 14'h0, 36'h0, 0);
    ebm_fabric_b_inst.acc(1'b0, 4'h0, 14'h0, 36'h0, 0);
    @(posedge hclk);
    a_clr <= 1'b1;
    b_clr <= 1'b1;
    #1;
    chk(a_rd, 36'h0, "async clear");
    chk(b_rd, word(4, 0), "sync clear waits");
    @(posedge hclk);
    a_clr <= 1'b0;
    b_clr <= 1'b0;
    #1;
    chk(b_rd, 36'h0, "sync clear");
    ebm_fabric_a_inst.acc(1'b0, 4'h0, 14'h0, 36'h0, 0);
    ebm_fabric_b_inst.acc(1'b0, 4'h0, 14'h0, 36'h0, 0);
    #1;
    chk(a_rd, word(4, 0), "a kept");
    // Port a clear alone leaves port b as it stands
    @(posedge hclk);
    a_clr <= 1'b1;
    #1;
    chk(b_rd, word(4, 0), "b untouched");
    @(posedge hclk);
    a_clr <= 1'b0;
    @(posedge hclk);
    dclr_n <= 1'b0;
    #1;
    chk(a_rd | b_rd, 36'h0, "device clear");
    @(posedge hclk);
    dclr_n <= 1'b1;
    $display("clears done");
    final_report();
  end
endmodule // ebm_top_tb
